// ==== pkg/irm_pkg.sv ====
// Function
// - Carrier timer is an 8-bit up counter, readable and writable.
// - Carrier clock select: divide oscillator by 1, 2, 4 or 8.
// - Enabling carrier timer starts counting with carrier output high.
// - Carrier output goes low once count exceeds duty value.
// - At period value carrier goes high and counter restarts from zero.
// - Carrier rise and fall flags set on each carrier edge made by the running timer.
// - Both timers set overflow flags when wrapping from all ones.
// - Envelope timer is 16-bit; clock is osc/1, /16, /64 or carrier.
// - Envelope counts ticks, compared with mark or space after increments.
// - Mark match drives modulator low and switches compare to space.
// - Space match resets envelope counter and returns modulator high.
// - Mark-match and space-match flags set on each match.
// - Carrier mode passes carrier to transmit pin during mark.
// - No-carrier mode drives 1 during mark and 0 during space.
// - With timers enabled a polarity bit selects output sense.
// - With timers disabled pin follows only transmit-state bit.
// - Output-mode bit 0 selects carrier mode, 1 no-carrier mode.
// - Polarity 0 passes signal, 1 inverts it.
// - Transmit-state 0 drives low, 1 high, in direct control.
package irm_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLKSEL = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_DUTY = 4'h3;
  localparam logic [3:0] ADDR_MARK = 4'h4;
  localparam logic [3:0] ADDR_SPACE = 4'h5;
  localparam logic [3:0] ADDR_CCOUNT = 4'h6;
  localparam logic [3:0] ADDR_ECOUNT = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam int CTRL_CEN = 0;
  localparam int CTRL_EEN = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_MODE = 3;
  localparam int CTRL_ENV = 5;
  localparam int CTRL_TXST = 6;
  localparam int CTRL_PINEN = 7;
  localparam int FLG_RISE = 0;
  localparam int FLG_FALL = 1;
  localparam int FLG_MARK = 2;
  localparam int FLG_SPACE = 3;
  localparam int FLG_COVF = 4;
  localparam int FLG_EOVF = 5;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] ENV_SEL_CARRIER = 2'h3;
  localparam logic [6:0] ENV_DIV16 = 7'h0f;
  localparam logic [6:0] ENV_DIV64 = 7'h3f;
endpackage : irm_pkg

// ==== pkg/irm_tick_if.sv ====
`timescale 1ns/1ps
// Ticks and selects shared between top and prescaler
interface irm_tick_if;
  logic [1:0] carrier_clk_sel;
  logic [1:0] envelope_clk_sel;
  logic carrier_tick;
  logic envelope_pre_tick;
  modport pre (input carrier_clk_sel, envelope_clk_sel,
               output carrier_tick, envelope_pre_tick);
  modport top (output carrier_clk_sel, envelope_clk_sel,
               input carrier_tick, envelope_pre_tick);
endinterface : irm_tick_if

// ==== src/irm_prescaler.sv ====
`timescale 1ns/1ps
module irm_prescaler
  import irm_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, low
  irm_tick_if.pre tk // Selects in, ticks out
);
  logic [6:0] div_cnt;
  logic [6:0] next_div_cnt;
  logic next_ctick;
  logic next_etick;
  logic ctick;
  logic etick;

  // Free running divider and tick decode
  always_comb begin
    next_div_cnt = div_cnt + 7'h01;
    case (tk.carrier_clk_sel)
      2'h0: next_ctick = 1'b1;
      2'h1: next_ctick = (div_cnt[0] == 1'b1);
      2'h2: next_ctick = (div_cnt[1:0] == 2'h3);
      default: next_ctick = (div_cnt[2:0] == 3'h7);
    endcase
    case (tk.envelope_clk_sel)
      2'h0: next_etick = 1'b1;
      2'h1: next_etick = ((div_cnt & ENV_DIV16) == ENV_DIV16);
      2'h2: next_etick = ((div_cnt & ENV_DIV64) == ENV_DIV64);
      default: next_etick = 1'b0;
    endcase
  end

  // Register divider and ticks
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt <= 7'h00;
      ctick <= 1'b0;
      etick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ctick <= next_ctick;
      etick <= next_etick;
    end
  end

  assign tk.carrier_tick = ctick;
  assign tk.envelope_pre_tick = etick;
endmodule : irm_prescaler

// ==== src/irm_slave.sv ====
`timescale 1ns/1ps
module irm_slave
  import irm_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, low
  input wire logic i_read, // Avalon read
  input wire logic i_write, // Avalon write
  output logic o_waitrequest, // Low on answer cycle
  output logic o_rd_go, // Read data load cycle
  output logic o_wr_go // Write accepted this cycle
);
  logic ack;
  logic next_ack;
  logic busy;
  logic next_busy;

  // One wait cycle, then accept
  always_comb begin
    next_ack = (i_read || i_write) && !ack;
    next_busy = !next_ack;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
      busy <= 1'b1;
    end else begin
      ack <= next_ack;
      busy <= next_busy;
    end
  end

  // Waitrequest straight from a flop
  assign o_waitrequest = busy;
  // Read data load in the wait cycle, so it stands at the accept edge
  assign o_rd_go = !ack && i_read;
  assign o_wr_go = ack && i_write;
endmodule : irm_slave

// ==== src/irm_modulator.sv ====
`timescale 1ns/1ps
module irm_modulator
  import irm_pkg::*;
(
  input wire logic i_clk, // System clock 40 MHz
  input wire logic i_rstn, // Async reset, low
  input wire logic [3:0] i_avs_address, // Word address
  input wire logic i_avs_read, // Read strobe
  input wire logic i_avs_write, // Write strobe
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte enables
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Wait request
  output logic o_ir_transmit_out, // Transmit pin level
  output logic o_tx_pin_enable // Pin used as transmit
);
  logic [7:0] ctrl;
  logic [1:0] carrier_clk_sel;
  logic [1:0] envelope_clk_sel;
  logic [7:0] period;
  logic [7:0] duty;
  logic [15:0] mark;
  logic [15:0] space;
  logic [7:0] ccount;
  logic [15:0] ecount;
  logic carrier;
  logic mark_active;
  logic [5:0] flags;
  logic [31:0] rdata;
  logic tx_out;
  logic [7:0] next_ctrl;
  logic [1:0] next_carrier_clk_sel;
  logic [1:0] next_envelope_clk_sel;
  logic [7:0] next_period;
  logic [7:0] next_duty;
  logic [15:0] next_mark;
  logic [15:0] next_space;
  logic [7:0] next_ccount;
  logic [15:0] next_ecount;
  logic next_carrier;
  logic next_mark_active;
  logic [5:0] next_flags;
  logic [5:0] set_flags;
  logic [31:0] next_rdata;
  logic next_tx_out;
  logic wr_go;
  logic rd_go;
  logic cen;
  logic een;
  logic etick;
  logic [7:0] cinc;
  logic [15:0] einc;
  logic pre_tx;
  logic b0;
  logic b1;
  // Carrier reload strobe and flag clears
  logic cwrap;
  logic [5:0] clr_flags;

  irm_tick_if tk ();

  assign tk.carrier_clk_sel = carrier_clk_sel;
  assign tk.envelope_clk_sel = envelope_clk_sel;

  irm_prescaler u_pre (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .tk(tk)
  );

  irm_slave u_slv (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .o_waitrequest(o_avs_waitrequest),
    .o_rd_go(rd_go),
    .o_wr_go(wr_go)
  );

  assign cen = ctrl[CTRL_CEN];
  assign een = ctrl[CTRL_EEN];
  assign b0 = wr_go && i_avs_byteenable[0];
  assign b1 = wr_go && i_avs_byteenable[1];

  // Carrier timer, envelope timer and flags
  always_comb begin
    next_ccount = ccount;
    next_carrier = carrier;
    next_ecount = ecount;
    next_mark_active = mark_active;
    set_flags = 6'h00;
    cinc = ccount + 8'h01;
    einc = ecount + 16'h0001;
    // Carrier reload ends one carrier period
    cwrap = cen && tk.carrier_tick && (cinc == period || ccount == period);
    // Carrier-rate envelope ticks once per carrier period
    if (envelope_clk_sel == ENV_SEL_CARRIER) begin
      etick = cwrap;
    end else begin
      etick = tk.envelope_pre_tick;
    end
    if (!cen) begin
      next_carrier = 1'b1;
    end else if (tk.carrier_tick) begin
      if (cwrap) begin
        next_ccount = 8'h00;
        next_carrier = 1'b1;
        if (!carrier) begin
          set_flags[FLG_RISE] = 1'b1;
        end
      end else begin
        next_ccount = cinc;
        if (cinc > duty) begin
          next_carrier = 1'b0;
          if (carrier) begin
            set_flags[FLG_FALL] = 1'b1;
          end
        end
      end
      if (ccount == 8'hff) begin
        set_flags[FLG_COVF] = 1'b1;
      end
    end
    if (!een) begin
      next_mark_active = 1'b1;
    end else if (etick) begin
      next_ecount = einc;
      if (ecount == 16'hffff) begin
        set_flags[FLG_EOVF] = 1'b1;
      end
      if (mark_active && einc == mark) begin
        next_mark_active = 1'b0;
        set_flags[FLG_MARK] = 1'b1;
      end else if (!mark_active && einc == space) begin
        next_ecount = 16'h0000;
        next_mark_active = 1'b1;
        set_flags[FLG_SPACE] = 1'b1;
      end
    end
    // Software writes override counters
    if (b0 && i_avs_address == ADDR_CCOUNT) begin
      next_ccount = i_avs_writedata[7:0];
    end
    if (i_avs_address == ADDR_ECOUNT) begin
      if (b0) begin
        next_ecount[7:0] = i_avs_writedata[7:0];
      end
      if (b1) begin
        next_ecount[15:8] = i_avs_writedata[15:8];
      end
    end
    // Ones written to the flag word clear those flags
    clr_flags = 6'h00;
    if (b0 && i_avs_address == ADDR_FLAGS) begin
      clr_flags = i_avs_writedata[5:0];
    end
  end

  // Per flag bit: a hardware set wins over a clear in the same cycle
  for (genvar f = 0; f < 6; f++) begin : g_flag
    assign next_flags[f] = set_flags[f] || (flags[f] && !clr_flags[f]);
  end

  // Configuration registers
  always_comb begin
    next_ctrl = ctrl;
    next_carrier_clk_sel = carrier_clk_sel;
    next_envelope_clk_sel = envelope_clk_sel;
    next_period = period;
    next_duty = duty;
    next_mark = mark;
    next_space = space;
    if (b0) begin
      case (i_avs_address)
        ADDR_CTRL: next_ctrl = i_avs_writedata[7:0];
        ADDR_CLKSEL: begin
          next_carrier_clk_sel = i_avs_writedata[1:0];
          next_envelope_clk_sel = i_avs_writedata[5:4];
        end
        ADDR_PERIOD: next_period = i_avs_writedata[7:0];
        ADDR_DUTY: next_duty = i_avs_writedata[7:0];
        ADDR_MARK: next_mark[7:0] = i_avs_writedata[7:0];
        ADDR_SPACE: next_space[7:0] = i_avs_writedata[7:0];
        default: ;
      endcase
    end
    if (b1) begin
      case (i_avs_address)
        ADDR_MARK: next_mark[15:8] = i_avs_writedata[15:8];
        ADDR_SPACE: next_space[15:8] = i_avs_writedata[15:8];
        default: ;
      endcase
    end
    next_ctrl[CTRL_ENV] = 1'b0;
  end

  // Read mux, loaded in the wait cycle so data stand at the accept edge
  always_comb begin
    next_rdata = rdata;
    if (rd_go) begin
      next_rdata = 32'h0000_0000;
      case (i_avs_address)
        ADDR_CTRL: begin
          next_rdata[7:0] = ctrl;
          next_rdata[CTRL_ENV] = mark_active && een;
        end
        ADDR_CLKSEL: next_rdata[5:0] = {envelope_clk_sel, 2'h0,
                                         carrier_clk_sel};
        ADDR_PERIOD: next_rdata[7:0] = period;
        ADDR_DUTY: next_rdata[7:0] = duty;
        ADDR_MARK: next_rdata[15:0] = mark;
        ADDR_SPACE: next_rdata[15:0] = space;
        ADDR_CCOUNT: next_rdata[7:0] = ccount;
        ADDR_ECOUNT: next_rdata[15:0] = ecount;
        ADDR_FLAGS: next_rdata[5:0] = flags;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Output control: mode gate, polarity or direct level
  always_comb begin
    // Mode gate before polarity
    if (ctrl[CTRL_MODE]) begin
      pre_tx = mark_active;
    end else begin
      pre_tx = carrier && mark_active;
    end
    // Direct level while both timers are stopped
    if (!cen && !een) begin
      next_tx_out = ctrl[CTRL_TXST];
    end else begin
      next_tx_out = pre_tx ^ ctrl[CTRL_POL];
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= RST_CTRL;
      carrier_clk_sel <= 2'h0;
      envelope_clk_sel <= 2'h0;
      period <= RST_BYTE;
      duty <= RST_BYTE;
      mark <= RST_WORD;
      space <= RST_WORD;
    end else begin
      ctrl <= next_ctrl;
      carrier_clk_sel <= next_carrier_clk_sel;
      envelope_clk_sel <= next_envelope_clk_sel;
      period <= next_period;
      duty <= next_duty;
      mark <= next_mark;
      space <= next_space;
    end
  end

  // Timer counters and waveform state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ccount <= RST_BYTE;
      ecount <= RST_WORD;
      carrier <= 1'b1;
      mark_active <= 1'b1;
    end else begin
      ccount <= next_ccount;
      ecount <= next_ecount;
      carrier <= next_carrier;
      mark_active <= next_mark_active;
    end
  end

  // Event flags
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags <= 6'h00;
    end else begin
      flags <= next_flags;
    end
  end

  // Read data and transmit level
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata <= 32'h0000_0000;
      tx_out <= 1'b0;
    end else begin
      rdata <= next_rdata;
      tx_out <= next_tx_out;
    end
  end

  assign o_avs_readdata = rdata;
  assign o_ir_transmit_out = tx_out;
  assign o_tx_pin_enable = ctrl[CTRL_PINEN];
endmodule : irm_modulator

// ==== verif/irm_modulator_props.sv ====
`timescale 1ns/1ps
module irm_modulator_props
  import irm_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Reset, low
  input wire logic [3:0] i_avs_address, // Address
  input wire logic i_avs_read, // Read
  input wire logic i_avs_write, // Write
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Lanes
  input wire logic [31:0] o_avs_readdata, // Read data
  input wire logic o_avs_waitrequest, // Wait
  input wire logic o_ir_transmit_out, // Pin level
  input wire logic o_tx_pin_enable // Pin enable
);
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic wr_ctl;
  logic rd_ok;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Shadow of the control byte
  always_comb begin
    wr_ctl = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
      && i_avs_address == ADDR_CTRL;
    rd_ok = i_avs_read && !o_avs_waitrequest;
    next_ctl = wr_ctl ? i_avs_writedata[7:0] : ctl;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl <= RST_CTRL;
    end else begin
      ctl <= next_ctl;
    end
  end
  property p_ack;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_rel;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_rel: assert property (p_rel) else $error("long answer");
  property p_idle;
    !(i_avs_read || i_avs_write) |-> o_avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("idle answer");
  property p_pinen;
    o_tx_pin_enable == ctl[CTRL_PINEN];
  endproperty
  a_pinen: assert property (p_pinen) else $error("pin enable");
  property p_direct;
    (!ctl[CTRL_CEN] && !ctl[CTRL_EEN] && $stable(ctl)) [*2]
      |-> o_ir_transmit_out == ctl[CTRL_TXST];
  endproperty
  a_direct: assert property (p_direct) else $error("direct");
  property p_unmap;
    rd_ok && i_avs_address > ADDR_FLAGS |-> o_avs_readdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_rdhold;
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("rdata moved");
  property p_rdctl;
    rd_ok && i_avs_address == ADDR_CTRL
      |-> o_avs_readdata[7:6] == ctl[7:6] && o_avs_readdata[3:0] == ctl[3:0];
  endproperty
  a_rdctl: assert property (p_rdctl) else $error("ctrl read");
  c_rd: cover property (rd_ok);
  c_wr: cover property (wr_ctl);
  c_fall: cover property ($fell(o_ir_transmit_out));
endmodule : irm_modulator_props

bind irm_modulator irm_modulator_props u_props (.i_clk, .i_rstn,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .o_ir_transmit_out, .o_tx_pin_enable);

// ==== verif/irm_emitter.sv ====
`timescale 1ns/1ps
module irm_emitter (
  input wire logic i_clk, // Clock
  input wire logic i_tx, // Pin level
  input wire logic i_en, // Pin enable
  output int o_on, // Lit cycles
  output int o_rises // Light onsets
);
  logic lit = 1'b0;
  initial begin
    o_on = 0;
    o_rises = 0;
  end
  // Lit only while the pin is a transmit pin
  always @(posedge i_clk) begin
    o_on <= o_on + int'(i_en && i_tx);
    o_rises <= o_rises + int'(i_en && i_tx && !lit);
    lit <= i_en && i_tx;
  end
endmodule : irm_emitter

// ==== verif/tb_ir_carrier_modulator.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: got %0h want %0h", $time, g, e); end end
module tb_ir_carrier_modulator;
  import irm_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = ZERO;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_ir_transmit_out;
  logic o_tx_pin_enable;
  int err_count = 0;
  int checks_done = 0;
  int led_on;
  int led_rises;
  int on;
  int ri;
  logic [31:0] q;
  irm_modulator DUT (.i_clk, .i_rstn, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .o_ir_transmit_out, .o_tx_pin_enable);
  irm_emitter u_led (.i_clk, .i_tx(o_ir_transmit_out),
    .i_en(o_tx_pin_enable), .o_on(led_on), .o_rises(led_rises));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    // Read data taken at the accept edge, then release
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    bus(a, 1'b0, ZERO);
  endtask : rd
  // Lit cycles and onsets seen by the emitter over n cycles
  task automatic watch(input int n);
    int o0 = led_on;
    int r0 = led_rises;
    repeat (n) @(posedge i_clk);
    on = led_on - o0;
    ri = led_rises - r0;
  endtask : watch
  task automatic t_regs;
    rd(ADDR_CTRL);
    `CHK(q[7:0], RST_CTRL)
    wr(ADDR_CCOUNT, 32'h0000_005a);
    rd(ADDR_CCOUNT);
    `CHK(q[7:0], 8'h5a)
    wr(ADDR_ECOUNT, 32'h0000_1234);
    rd(ADDR_ECOUNT);
    `CHK(q[15:0], 16'h1234)
    wr(4'hf, 32'h0000_00ff);
    rd(4'hf);
    `CHK(q, ZERO)
  endtask : t_regs
  task automatic t_direct;
    wr(ADDR_CTRL, 32'h0000_00c4);
    repeat (2) @(posedge i_clk);
    `CHK(o_ir_transmit_out, 1'b1)
    `CHK(o_tx_pin_enable, 1'b1)
    wr(ADDR_CTRL, 32'h0000_0084);
    repeat (2) @(posedge i_clk);
    `CHK(o_ir_transmit_out, 1'b0)
  endtask : t_direct
  // Envelope alone, mark 4 and space at 10, both senses
  task automatic t_env;
    wr(ADDR_CLKSEL, ZERO);
    wr(ADDR_ECOUNT, ZERO);
    wr(ADDR_MARK, 32'h0000_0004);
    wr(ADDR_SPACE, 32'h0000_000a);
    wr(ADDR_FLAGS, 32'h0000_003f);
    wr(ADDR_CTRL, 32'h0000_008a);
    repeat (20) @(posedge i_clk);
    watch(100);
    `CHK(on, 40)
    `CHK(ri, 10)
    rd(ADDR_FLAGS);
    `CHK(q[3:2], 2'b11)
    wr(ADDR_CTRL, 32'h0000_008e);
    repeat (20) @(posedge i_clk);
    watch(100);
    `CHK(on, 60)
  endtask : t_env
  // Carrier period 8 duty 3 under every divider code
  task automatic t_car;
    wr(ADDR_CTRL, ZERO);
    wr(ADDR_PERIOD, 32'h0000_0008);
    wr(ADDR_DUTY, 32'h0000_0003);
    wr(ADDR_CCOUNT, ZERO);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CLKSEL, 32'(k));
      wr(ADDR_CTRL, 32'h0000_0081);
      repeat (70) @(posedge i_clk);
      watch(320);
      `CHK(ri, 40 >> k)
      `CHK(on, 160)
    end
    rd(ADDR_FLAGS);
    `CHK(q[1:0], 2'b11)
  endtask : t_car
  // Carrier gated by an envelope ticking once per carrier period
  task automatic t_gate;
    wr(ADDR_ECOUNT, ZERO);
    wr(ADDR_MARK, 32'h0000_0002);
    wr(ADDR_SPACE, 32'h0000_0004);
    wr(ADDR_CLKSEL, 32'h0000_0030);
    wr(ADDR_CTRL, 32'h0000_0083);
    repeat (70) @(posedge i_clk);
    watch(320);
    `CHK(ri, 20)
    `CHK(on, 80)
  endtask : t_gate
  task automatic t_ovf;
    wr(ADDR_CTRL, ZERO);
    wr(ADDR_FLAGS, 32'h0000_003f);
    wr(ADDR_CLKSEL, ZERO);
    wr(ADDR_CCOUNT, 32'h0000_00f0);
    wr(ADDR_ECOUNT, 32'h0000_fff0);
    wr(ADDR_CTRL, 32'h0000_0003);
    repeat (40) @(posedge i_clk);
    wr(ADDR_CTRL, ZERO);
    rd(ADDR_FLAGS);
    `CHK(q[5:4], 2'b11)
    wr(ADDR_FLAGS, 32'h0000_0030);
    rd(ADDR_FLAGS);
    `CHK(q[5:4], 2'b00)
  endtask : t_ovf
  task automatic results;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_direct();
    t_env();
    t_car();
    t_gate();
    t_ovf();
    results();
  end
  // Watchdog, well past the expected run
  initial begin
    #250_000;
    err_count++;
    results();
  end
endmodule : tb_ir_carrier_modulator
